// *** sfr_map_page_protect_params.svh ***
// Purpose: Constants for the register map, paging and protection logic.
// Assumes: Byte-wide registers on the core register port.
// Notes: Offsets are local indices on the register port.
`ifndef SFR_MAP_PAGE_PROTECT_PARAMS_SVH
`define SFR_MAP_PAGE_PROTECT_PARAMS_SVH

`define SYSCON_OFFSET 8'h8F
`define WINDOW_OFFSET 8'hB1
`define KEY_OFFSET 8'hBB
`define CLKCTL_OFFSET 8'hB7
`define PWRCTL_OFFSET 8'hB8

`define SYSCON_RESET 8'h04
`define SYSCON_ONE_MASK 8'h04
`define SYSCON_MAP_BIT 0
`define WINDOW_RESET 8'h00
`define KEY_MODE_RESET 2'h3

`define KEY_OPEN 5'h13
`define KEY_CLOSE 5'h15
`define KEY_MODE_SET 5'h18
`define MODE_PROTECT 2'h3

`define OPEN_TIME_CYCLES 32
`define OPEN_COUNT_W 6

`endif

// *** sfr_map_page_protect_pkg.sv ***
// Purpose: Types shared by the register map, paging and protection logic.
// Assumes: Byte-wide register port.
// Notes: Struct carries one register access.
package sfr_map_page_protect_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      ACT_MANUAL0,
      ACT_MANUAL1,
      ACT_SAVE,
      ACT_RESTORE
   } window_action_t;

endpackage

// *** sfr_map_page_protect.sv ***
// Purpose: Register map select, module paging and bit write protection.
// Assumes: One core clock; register port driven by logic on that clock.
// Notes: Protected fields are outputs that feed clocking and power logic.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_map_page_protect_params.svh"

// Overview of operation
// - Map bit 0 picks standard or mapped area
// - Control resets 04, bit 2 reads one
// - Paged decode uses window page field
// - Action 0X writes page directly
// - Action 10 writes page, saves old one
// - Action 11 restores page from slot
// - Window bit 3 reads zero
// - Mode 11, key 10011 opens access
// - Key 10101 closes access immediately
// - Only key 11000 updates mode field
// - Open access expires after 32 cycles
// - Reopening restarts the 32-cycle window
// - Dividers, watchdog, power bits are protected
module sfr_map_page_protect #(
   parameter int PAGE_W = 3,
   parameter int SLOT_W = 2
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire sfr_map_page_protect_pkg::reg_req_t req_i,
   output logic [7:0] rdata_o,
   output logic sfr_map_select_o,
   output logic [PAGE_W-1:0] page_o,
   output logic access_open_o,
   output logic [4:0] feedback_divider_o,
   output logic [1:0] output_divider_o,
   output logic watchdog_on_o,
   output logic deep_sleep_enable_o,
   output logic slow_run_enable_o
);
   import sfr_map_page_protect_pkg::*;

   localparam int NSLOT = 1 << SLOT_W;

   // Page sits below reserved bit 3, slot number in bits 5:4
   if (PAGE_W < 1 || PAGE_W > 3 || SLOT_W < 1 || SLOT_W > 2) begin : g_bad_w
      $error("Page or slot width outside the window register layout");
   end

   ////////////////////////////////////////////////////////////////////////
   // State
   logic map_sel, next_map_sel;
   logic [PAGE_W-1:0] page, next_page;
   logic [PAGE_W-1:0] slot [NSLOT];
   logic [PAGE_W-1:0] next_slot [NSLOT];
   logic [1:0] mode, next_mode;
   logic open, next_open;
   logic [`OPEN_COUNT_W-1:0] cnt, next_cnt;
   logic [4:0] fdiv, next_fdiv;
   logic [1:0] odiv, next_odiv;
   logic wdt, next_wdt, pd, next_pd, sd, next_sd;
   logic [7:0] rdata, next_rdata;

   function automatic logic hit(input reg_req_t r, input logic [7:0] a);
      return r.wr && r.addr == a;
   endfunction

   // Protection off (mode not 11) lets every protected write through
   logic wr_ok;
   assign wr_ok = open || (mode != `MODE_PROTECT);

   ////////////////////////////////////////////////////////////////////////
   // Map select and paging
   always_comb begin
      window_action_t act;
      logic [SLOT_W-1:0] sn;
      act = window_action_t'(req_i.wdata[7:6]);
      sn = req_i.wdata[4+:SLOT_W];
      next_map_sel = map_sel;
      next_page = page;
      next_slot = slot;
      if (hit(req_i, `SYSCON_OFFSET)) begin
         next_map_sel = req_i.wdata[`SYSCON_MAP_BIT];
      end
      if (hit(req_i, `WINDOW_OFFSET)) begin
         unique case (act)
            ACT_MANUAL0, ACT_MANUAL1: begin
               next_page = req_i.wdata[PAGE_W-1:0];
            end
            ACT_SAVE: begin
               next_page = req_i.wdata[PAGE_W-1:0];
               next_slot[sn] = page;
            end
            ACT_RESTORE: begin
               next_page = slot[sn];
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         map_sel <= 1'b0;
         page <= '0;
         for (int i = 0; i < NSLOT; i++) begin
            slot[i] <= '0;
         end
      end else begin
         map_sel <= next_map_sel;
         page <= next_page;
         slot <= next_slot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Password and access window
   always_comb begin
      logic [4:0] key;
      key = req_i.wdata[7:3];
      next_mode = mode;
      next_open = open;
      next_cnt = cnt;
      if (open) begin
         // Count down; reaching zero closes with no close key
         next_cnt = cnt - `OPEN_COUNT_W'(1);
         if (cnt == `OPEN_COUNT_W'(1)) begin
            next_open = 1'b0;
         end
      end
      if (hit(req_i, `KEY_OFFSET)) begin
         if (key == `KEY_MODE_SET) begin
            next_mode = req_i.wdata[1:0];
         end else if (mode == `MODE_PROTECT && key == `KEY_OPEN) begin
            next_open = 1'b1;
            next_cnt = `OPEN_COUNT_W'(`OPEN_TIME_CYCLES);
         end else if (mode == `MODE_PROTECT && key == `KEY_CLOSE) begin
            next_open = 1'b0;
            next_cnt = '0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode <= `KEY_MODE_RESET;
         open <= 1'b0;
         cnt <= '0;
      end else begin
         mode <= next_mode;
         open <= next_open;
         cnt <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Protected bits
   always_comb begin
      next_fdiv = fdiv;
      next_odiv = odiv;
      next_wdt = wdt;
      next_pd = pd;
      next_sd = sd;
      if (hit(req_i, `CLKCTL_OFFSET) && wr_ok) begin
         next_fdiv = req_i.wdata[7:3];
         next_odiv = req_i.wdata[1:0];
      end
      if (hit(req_i, `PWRCTL_OFFSET) && wr_ok) begin
         next_wdt = req_i.wdata[2];
         next_pd = req_i.wdata[1];
         next_sd = req_i.wdata[0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fdiv <= '0;
         odiv <= '0;
         wdt <= 1'b0;
         pd <= 1'b0;
         sd <= 1'b0;
      end else begin
         fdiv <= next_fdiv;
         odiv <= next_odiv;
         wdt <= next_wdt;
         pd <= next_pd;
         sd <= next_sd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, registered one cycle after the read strobe
   always_comb begin
      next_rdata = rdata;
      if (req_i.rd) begin
         unique case (req_i.addr)
            `SYSCON_OFFSET: next_rdata = `SYSCON_ONE_MASK | {7'h00, map_sel};
            `WINDOW_OFFSET: next_rdata = 8'(page);
            `KEY_OFFSET: next_rdata = {5'h00, open, mode};
            `CLKCTL_OFFSET: next_rdata = {fdiv, 1'b0, odiv};
            `PWRCTL_OFFSET: next_rdata = {5'h00, wdt, pd, sd};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign rdata_o = rdata;
   assign sfr_map_select_o = map_sel;
   assign page_o = page;
   assign access_open_o = open;
   assign feedback_divider_o = fdiv;
   assign output_divider_o = odiv;
   assign watchdog_on_o = wdt;
   assign deep_sleep_enable_o = pd;
   assign slow_run_enable_o = sd;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence open_key_s;
      hit(req_i, `KEY_OFFSET) && req_i.wdata[7:3] == `KEY_OPEN
         && mode == `MODE_PROTECT;
   endsequence

   sequence quiet_key_s;
      !hit(req_i, `KEY_OFFSET) [*8];
   endsequence

   open_key_a: assert property (open_key_s |=> open && cnt == 6'd32)
      else $error("Open key did not open access for 32 cycles");
   close_key_a: assert property (hit(req_i, `KEY_OFFSET)
      && req_i.wdata[7:3] == `KEY_CLOSE && mode == `MODE_PROTECT |=> !open)
      else $error("Close key did not close access");
   mode_hold_a: assert property (hit(req_i, `KEY_OFFSET)
      && req_i.wdata[7:3] != `KEY_MODE_SET |=> $stable(mode))
      else $error("Mode changed without mode key");
   expire_a: assert property (open && cnt == 6'd1
      && !(hit(req_i, `KEY_OFFSET) && req_i.wdata[7:3] == `KEY_OPEN
      && mode == `MODE_PROTECT) |=> !open)
      else $error("Access did not close after 32 cycles");
   reopen_a: assert property (open_key_s ##1 quiet_key_s |=> open)
      else $error("Access closed early after open key");
   protect_a: assert property (!wr_ok && hit(req_i, `PWRCTL_OFFSET)
      |=> $stable({wdt, pd, sd}))
      else $error("Protected bit changed while closed");
   save_page_a: assert property (hit(req_i, `WINDOW_OFFSET)
      && req_i.wdata[7:6] == 2'b10 |=> slot[$past(req_i.wdata[5:4])]
      == $past(page))
      else $error("Previous page not saved");
   restore_a: assert property (hit(req_i, `WINDOW_OFFSET)
      && req_i.wdata[7:6] == 2'b11 |=> page == $past(slot[req_i.wdata[5:4]]))
      else $error("Page not restored from slot");
   syscon_rd_a: assert property (req_i.rd && req_i.addr == `SYSCON_OFFSET
      |=> rdata_o[2] && rdata_o[7:3] == 5'h00 && !rdata_o[1])
      else $error("Control register reserved bits wrong");
   map_a: assert property (hit(req_i, `SYSCON_OFFSET)
      |=> sfr_map_select_o == $past(req_i.wdata[0]))
      else $error("Map select did not follow write");

   // Paging: written page taken in both direct and saving actions
   manual_page_a: assert property (hit(req_i, `WINDOW_OFFSET)
      && !req_i.wdata[7] |=> page == $past(req_i.wdata[PAGE_W-1:0]))
      else $error("Manual page write not taken");
   save_new_page_a: assert property (hit(req_i, `WINDOW_OFFSET)
      && req_i.wdata[7:6] == 2'b10
      |=> page == $past(req_i.wdata[PAGE_W-1:0]))
      else $error("New page not taken on save");
   window_rd_a: assert property (req_i.rd && req_i.addr == `WINDOW_OFFSET
      |=> rdata_o[7:3] == 5'h00)
      else $error("Window reserved bits read nonzero");

   // Key register and protected writes
   mode_set_a: assert property (hit(req_i, `KEY_OFFSET)
      && req_i.wdata[7:3] == `KEY_MODE_SET
      |=> mode == $past(req_i.wdata[1:0]))
      else $error("Mode key did not update mode");
   unprot_open_a: assert property (hit(req_i, `KEY_OFFSET)
      && mode != `MODE_PROTECT && !open |=> !open)
      else $error("Open key acted with protection off");
   protect_clk_a: assert property (!wr_ok && hit(req_i, `CLKCTL_OFFSET)
      |=> $stable({fdiv, odiv}))
      else $error("Divider changed while closed");
   open_pwr_a: assert property (wr_ok && hit(req_i, `PWRCTL_OFFSET)
      |=> {wdt, pd, sd} == $past(req_i.wdata[2:0]))
      else $error("Protected bit write lost while open");
   open_clk_a: assert property (wr_ok && hit(req_i, `CLKCTL_OFFSET)
      |=> fdiv == $past(req_i.wdata[7:3]))
      else $error("Divider write lost while open");

endmodule // sfr_map_page_protect
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for map select, paging and key protection.
// Assumes: Design default widths, page 3 bits and slot 2 bits.
// Notes: Inputs move on the falling edge; one idle cycle between requests.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_map_page_protect_params.svh"
module tb_top;
   import sfr_map_page_protect_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   reg_req_t req_i = '0;
   logic [7:0] rdata_o;
   logic [2:0] page_o;
   logic [4:0] fdiv;
   logic [1:0] odiv;
   logic map, open_o, wdt, pd, sd;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;

   sfr_map_page_protect i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .req_i(req_i), .rdata_o(rdata_o), .sfr_map_select_o(map),
      .page_o(page_o), .access_open_o(open_o), .feedback_divider_o(fdiv),
      .output_divider_o(odiv), .watchdog_on_o(wdt),
      .deep_sleep_enable_o(pd), .slow_run_enable_o(sd));

   always #50 clk_i = ~clk_i;

   task automatic close_out;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Bound well above the few hundred cycles the sequence needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end

   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      req_i.wr <= 1'b1;
      req_i.addr <= a;
      req_i.wdata <= d;
      @(posedge clk_i);
      @(negedge clk_i);
      req_i.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk_i);
      req_i.rd <= 1'b1;
      req_i.addr <= a;
      @(posedge clk_i);
      @(negedge clk_i);
      req_i.rd <= 1'b0;
      q = rdata_o;
   endtask

   // Counts falling edges with the protected window still open
   task automatic count_open(output int n);
      n = 0;
      while (open_o === 1'b1 && n < 40) begin
         n++;
         @(negedge clk_i);
      end
   endtask

   function automatic logic [7:0] key_exp(input logic op, input logic [1:0] m);
      return {5'h00, op, m};
   endfunction

   function automatic logic [7:0] clk_exp(input logic [7:0] d);
      return {d[7:3], 1'b0, d[1:0]};
   endfunction

   initial begin
      logic [7:0] q, d;
      logic [2:0] page;
      logic [2:0] slots [4];
      logic [3:0] saved;
      logic [1:0] act, s;
      int n;
      page = 3'h0;
      saved = 4'h0;
      void'($urandom(32'hE68F));
      repeat (20) @(negedge clk_i);
      arst_n_i = 1'b1;
      rd(`SYSCON_OFFSET, q);
      check("syscon", q, 8'h04);
      check("outs", {map, open_o, page_o, wdt, pd, sd}, 8'h00);
      // Map bit changed by read-modify-write, reserved bits kept
      wr(`SYSCON_OFFSET, q | 8'h01);
      rd(`SYSCON_OFFSET, q);
      check("syscon", q, 8'h05);
      check("map", {7'h00, map}, 8'h01);
      wr(`SYSCON_OFFSET, q & 8'hFE);
      check("map", {7'h00, map}, 8'h00);
      for (int i = 0; i < 40; i++) begin
         act = 2'($urandom_range(3));
         s = 2'($urandom_range(3));
         if (act == 2'h3 && saved[s] !== 1'b1) act = 2'h2;
         d = {act, s, 1'b0, 3'($urandom_range(7))};
         wr(`WINDOW_OFFSET, d);
         if (act == 2'h2) begin
            slots[s] = page;
            saved[s] = 1'b1;
         end
         page = (act == 2'h3) ? slots[s] : d[2:0];
         check("page", {5'h00, page_o}, {5'h00, page});
         rd(`WINDOW_OFFSET, q);
         check("window", q, {5'h00, page});
      end
      wr(`CLKCTL_OFFSET, 8'hFF);
      wr(`PWRCTL_OFFSET, 8'h07);
      check("clk", {fdiv, 1'b0, odiv}, 8'h00);
      check("pwr", {5'h00, wdt, pd, sd}, 8'h00);
      wr(`KEY_OFFSET, 8'h98);
      check("open", {7'h00, open_o}, 8'h01);
      rd(`KEY_OFFSET, q);
      check("key", q, key_exp(1'b1, 2'h3));
      d = 8'($urandom);
      wr(`CLKCTL_OFFSET, d);
      wr(`PWRCTL_OFFSET, 8'h05);
      check("clk", {fdiv, 1'b0, odiv}, clk_exp(d));
      check("pwr", {5'h00, wdt, pd, sd}, 8'h05);
      wr(`KEY_OFFSET, 8'hA8);
      check("open", {7'h00, open_o}, 8'h00);
      rd(`KEY_OFFSET, q);
      check("key", q, key_exp(1'b0, 2'h3));
      wr(`CLKCTL_OFFSET, ~d);
      check("clk", {fdiv, 1'b0, odiv}, clk_exp(d));
      wr(`KEY_OFFSET, 8'h98);
      count_open(n);
      check("window len", 8'(n), 8'd32);
      wr(`KEY_OFFSET, 8'h98);
      repeat (20) @(negedge clk_i);
      wr(`KEY_OFFSET, 8'h98);
      count_open(n);
      check("reopen len", 8'(n), 8'd32);
      // Mode key is 11000 in bits 7:3, new mode 00 in bits 1:0
      wr(`KEY_OFFSET, 8'hC0);
      rd(`KEY_OFFSET, q);
      check("key", q, key_exp(1'b0, 2'h0));
      wr(`KEY_OFFSET, 8'h98);
      check("open", {7'h00, open_o}, 8'h00);
      wr(`CLKCTL_OFFSET, ~d);
      check("clk", {fdiv, 1'b0, odiv}, clk_exp(~d));
      rd(`CLKCTL_OFFSET, q);
      check("clk rd", q, clk_exp(~d));
      rd(`PWRCTL_OFFSET, q);
      check("pwr rd", q, 8'h05);
      wr(`KEY_OFFSET, 8'hC3);
      rd(`KEY_OFFSET, q);
      check("key", q, key_exp(1'b0, 2'h3));
      close_out();
   end
endmodule // tb_top
`default_nettype wire
